// [verilog/spdb_pkg.sv]
// Constants, types and register map of the serial ping-pong DMA with baud divider
// ----------------
// How it works
// [RULE1] Bit rate is 24 MHz divided by twice the 16-bit integer period plus fraction.
// [RULE2] One fraction bit adds one unit to the doubled divisor: half-step resolution.
// [RULE3] Each channel owns buffers A and B and switches between them by itself.
// [RULE4] Bytes move between FIFO and active buffer whenever the FIFO can take or give.
// [RULE5] Unloading sets its own flag: transmit A, transmit B, receive A, receive B.
// [RULE6] A buffer is idle, pending or active; unloading returns it to idle.
// [RULE7] Software resets, programs addresses, sets up interrupts, then loads buffers.
// [RULE8] Software gives start and inclusive end address; buffers lie in RAM only.
// [RULE9] End address writes are taken while pending or active and used at once.
// [RULE10] Count is byte offset of next byte from start; plus one per byte.
// [RULE11] Transmit shares one count; receive keeps separate counts for A and B.
// [RULE12] A count holds until its buffer (transmit: either) loads or channel resets.
// [RULE13] Receive count is writable; writing it while idle also loads, keeping value.
// [RULE14] Buffer unloads once start plus count exceeds the end address.
// [RULE15] Unload test is re-made after end or count writes, allowing early unload.
// [RULE16] Channel reset bits reset their channel and clear by themselves.
// [RULE17] Loading A and B together makes A active and leaves B pending.
// [RULE18] Load bits set on one, ignore zero, read one while pending or active.
// [RULE19] After channel reset both its buffers are idle, no transfer, no pending load.
// ----------------
package spdb_pkg;

   // ----------------
   // Register byte addresses
   // ----------------
   localparam logic [31:0] ADDR_BUF_BASE = 32'h4000_C800; // 8 bytes per buffer: start, end
   localparam logic [31:0] ADDR_TX_COUNT = 32'h4000_C820;
   localparam logic [31:0] ADDR_RX_COUNT_A = 32'h4000_C824;
   localparam logic [31:0] ADDR_RX_COUNT_B = 32'h4000_C828;
   localparam logic [31:0] ADDR_STATUS = 32'h4000_C82C;
   localparam logic [31:0] ADDR_CONTROL = 32'h4000_C830;
   localparam logic [31:0] ADDR_IRQ_FLAG = 32'h4000_C840;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_C844;
   localparam logic [31:0] ADDR_BAUD_PER_CH1 = 32'h4000_C868;
   localparam logic [31:0] ADDR_BAUD_FRAC_CH1 = 32'h4000_C86C;
   localparam logic [31:0] ADDR_BAUD_PER_CH3 = 32'h4000_D868;
   localparam logic [31:0] ADDR_BAUD_FRAC_CH3 = 32'h4000_D86C;

   // ----------------
   // Field positions and reset values
   // ----------------
   localparam int CTRL_LOAD_LSB = 0; // rx A, rx B, tx A, tx B
   localparam int CTRL_RX_RST_BIT = 4;
   localparam int CTRL_TX_RST_BIT = 5;
   localparam int BUF_FIELD_LSB = 3; // address bits selecting the buffer
   localparam int BUF_END_BIT = 2; // address bit choosing end over start
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [15:0] RESET_BAUD_PER = 16'h0000;

   // ----------------
   // Timing: reference of the baud divider and the system clock, in MHz
   // ----------------
   localparam logic [31:0] BAUD_REF_MHZ = 32'h0000_0018;
   localparam logic [31:0] SYS_CLK_MHZ = 32'h0000_0064;

   // ----------------
   // Types
   // ----------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TX_READ = 2'b01,
      ST_RX_WRITE = 2'b10
   } spdb_state_e;

   typedef struct packed {
      logic write;
      logic [31:0] addr;
      logic [7:0] wdata;
   } spdb_mem_s;

endpackage : spdb_pkg

// [verilog/spdb_dma.sv]
// Serial ping-pong DMA channels with APB registers and fractional baud dividers
//
// Added by the designer: the APB interface to the registers.
module spdb_dma
   import spdb_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output spdb_mem_s o_mem_cmd,
   output logic o_mem_valid,
   input wire logic i_mem_ack,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_tx_fifo_space,
   output logic o_tx_fifo_push,
   output logic [7:0] o_tx_fifo_data,
   input wire logic i_rx_fifo_avail,
   input wire logic [7:0] i_rx_fifo_data,
   output logic o_rx_fifo_pop,
   output logic o_baud_tick_ch1,
   output logic o_baud_tick_ch3,
   output logic o_irq
);

   // ----------------
   // Helper functions
   // ----------------
   // Unload test; 33-bit sum so a buffer near the top of memory cannot wrap
   function automatic logic past_end(input logic [31:0] beg, input logic [31:0] cnt, input logic [31:0] last);
      logic [32:0] sum;
      sum = {1'b0, beg} + {1'b0, cnt};
      past_end = sum > {1'b0, last};
   endfunction : past_end

   // One step of the fractional rate accumulator: {tick, new accumulator}
   function automatic logic [32:0] baud_step(input logic [31:0] acc, input logic [15:0] per, input logic frac);
      logic [31:0] div;
      logic [31:0] lim;
      logic [31:0] sum;
      div = {15'h0000, per, 1'b0} + {31'h0000_0000, frac}; // RULE2
      lim = 32'(SYS_CLK_MHZ * div);
      sum = acc + BAUD_REF_MHZ;
      if (div == 32'h0000_0000) begin
         baud_step = {1'b0, 32'h0000_0000};
      end else if (sum >= lim) begin
         baud_step = {1'b1, 32'(sum - lim)}; // RULE1
      end else begin
         baud_step = {1'b0, sum};
      end
   endfunction : baud_step

   // ----------------
   // State
   // ----------------
   logic [31:0] beg_reg [4]; // index 0 rx A, 1 rx B, 2 tx A, 3 tx B
   logic [31:0] end_reg [4];
   logic [31:0] tx_cnt_reg;
   logic [31:0] rx_cnt_reg [2];
   logic [3:0] loaded_reg;
   logic rx_sel_reg;
   logic tx_sel_reg;
   logic [3:0] flag_reg;
   logic [3:0] mask_reg;
   spdb_state_e state_reg;
   logic xfer_buf_reg;
   logic last_tx_reg;
   logic [15:0] per_reg [2];
   logic frac_reg [2];
   logic [31:0] acc_reg [2];

   // ----------------
   // APB decode
   // ----------------
   wire setup = i_psel & ~i_penable;
   wire access = i_psel & i_penable & o_pready;
   wire wr = access & i_pwrite;
   wire rd = access & ~i_pwrite;
   wire buf_hit = i_paddr[31:5] == ADDR_BUF_BASE[31:5];
   wire [1:0] buf_idx = i_paddr[BUF_FIELD_LSB +: 2];
   wire hit_txcnt = i_paddr == ADDR_TX_COUNT;
   wire hit_rxcnt_a = i_paddr == ADDR_RX_COUNT_A;
   wire hit_rxcnt_b = i_paddr == ADDR_RX_COUNT_B;
   wire hit_stat = i_paddr == ADDR_STATUS;
   wire hit_ctrl = i_paddr == ADDR_CONTROL;
   wire hit_flag = i_paddr == ADDR_IRQ_FLAG;
   wire hit_mask = i_paddr == ADDR_IRQ_MASK;
   wire hit_per1 = i_paddr == ADDR_BAUD_PER_CH1;
   wire hit_frac1 = i_paddr == ADDR_BAUD_FRAC_CH1;
   wire hit_per3 = i_paddr == ADDR_BAUD_PER_CH3;
   wire hit_frac3 = i_paddr == ADDR_BAUD_FRAC_CH3;
   wire mapped = buf_hit | hit_txcnt | hit_rxcnt_a | hit_rxcnt_b | hit_stat | hit_ctrl |
                 hit_flag | hit_mask | hit_per1 | hit_frac1 | hit_per3 | hit_frac3;

   // Control strobes; reset bits are never stored, so they read back zero
   wire ctrl_wr = wr & hit_ctrl;
   wire rst_rx = ctrl_wr & i_pwdata[CTRL_RX_RST_BIT]; // RULE16
   wire rst_tx = ctrl_wr & i_pwdata[CTRL_TX_RST_BIT]; // RULE16
   wire [3:0] ld_ctrl = ctrl_wr ? i_pwdata[CTRL_LOAD_LSB +: 4] : 4'h0; // RULE18
   wire rxcnt_wr_a = wr & hit_rxcnt_a;
   wire rxcnt_wr_b = wr & hit_rxcnt_b;

   // ----------------
   // Buffer states and unload test
   // ----------------
   // Active is loaded and selected; loaded but not selected is pending
   wire [3:0] act = {loaded_reg[3] & tx_sel_reg, loaded_reg[2] & ~tx_sel_reg,
                     loaded_reg[1] & rx_sel_reg, loaded_reg[0] & ~rx_sel_reg}; // RULE6

   // Evaluated every cycle, so end or count writes take effect at once
   wire [3:0] over = {past_end(beg_reg[3], tx_cnt_reg, end_reg[3]),
                      past_end(beg_reg[2], tx_cnt_reg, end_reg[2]),
                      past_end(beg_reg[1], rx_cnt_reg[1], end_reg[1]),
                      past_end(beg_reg[0], rx_cnt_reg[0], end_reg[0])}; // RULE14 RULE15 RULE9
   wire [3:0] unload = act & over; // RULE14

   // Count write on an idle receive buffer loads it as well
   wire [3:0] ld_set = ld_ctrl | {2'b00, rxcnt_wr_b & ~loaded_reg[1],
                                  rxcnt_wr_a & ~loaded_reg[0]}; // RULE13
   wire [3:0] ch_rst = {rst_tx, rst_tx, rst_rx, rst_rx};
   wire [3:0] kept = loaded_reg & ~unload;
   wire [3:0] fresh = ld_set & ~kept; // Real idle-to-loaded transitions
   wire [3:0] loaded_next = (kept | ld_set) & ~ch_rst; // RULE19 RULE6

   // Selection: first load picks A over B, an unload hands over to the other buffer
   wire rx_sel_next = rst_rx ? 1'b0 :
                      (kept[1:0] == 2'b00 && ld_set[1:0] != 2'b00) ? ~ld_set[0] : // RULE17
                      (unload[1:0] != 2'b00) ? ~rx_sel_reg : rx_sel_reg; // RULE3
   wire tx_sel_next = rst_tx ? 1'b0 :
                      (kept[3:2] == 2'b00 && ld_set[3:2] != 2'b00) ? ~ld_set[2] : // RULE17
                      (unload[3:2] != 2'b00) ? ~tx_sel_reg : tx_sel_reg; // RULE3

   // ----------------
   // Transfer requests
   // ----------------
   wire rx_go = (act[1:0] != 2'b00) & (unload[1:0] == 2'b00) & i_rx_fifo_avail & ~rst_rx; // RULE4
   wire tx_go = (act[3:2] != 2'b00) & (unload[3:2] == 2'b00) & i_tx_fifo_space & ~rst_tx; // RULE4
   wire pick_rx = rx_go & (~tx_go | last_tx_reg); // Alternate when both want the bus
   wire [31:0] rx_addr = 32'(beg_reg[{1'b0, rx_sel_reg}] + rx_cnt_reg[rx_sel_reg]); // RULE10
   wire [31:0] tx_addr = 32'(beg_reg[{1'b1, tx_sel_reg}] + tx_cnt_reg); // RULE10
   wire rx_ack = (state_reg == ST_RX_WRITE) & i_mem_ack & ~rst_rx;
   wire tx_ack = (state_reg == ST_TX_READ) & i_mem_ack & ~rst_tx;

   // Flags read back are the ones cleared, so a flag set meanwhile survives
   wire [3:0] flag_clr = (rd & hit_flag) ? o_prdata[3:0] : 4'h0;
   wire [3:0] flag_next = (flag_reg & ~flag_clr) | unload; // RULE5

   wire [32:0] step1 = baud_step(acc_reg[0], per_reg[0], frac_reg[0]);
   wire [32:0] step3 = baud_step(acc_reg[1], per_reg[1], frac_reg[1]);

   // ----------------
   // Read multiplexer
   // ----------------
   logic [31:0] rd_word;
   always_comb begin
      rd_word = RESET_WORD;
      if (buf_hit) begin
         rd_word = i_paddr[BUF_END_BIT] ? end_reg[buf_idx] : beg_reg[buf_idx];
      end else begin
         case (i_paddr)
            ADDR_TX_COUNT: rd_word = tx_cnt_reg;
            ADDR_RX_COUNT_A: rd_word = rx_cnt_reg[0];
            ADDR_RX_COUNT_B: rd_word = rx_cnt_reg[1];
            ADDR_STATUS: rd_word = {28'h000_0000, act};
            ADDR_CONTROL: rd_word = {28'h000_0000, loaded_reg}; // RULE18
            ADDR_IRQ_FLAG: rd_word = {28'h000_0000, flag_reg};
            ADDR_IRQ_MASK: rd_word = {28'h000_0000, mask_reg};
            ADDR_BAUD_PER_CH1: rd_word = {16'h0000, per_reg[0]};
            ADDR_BAUD_FRAC_CH1: rd_word = {31'h0000_0000, frac_reg[0]};
            ADDR_BAUD_PER_CH3: rd_word = {16'h0000, per_reg[1]};
            ADDR_BAUD_FRAC_CH3: rd_word = {31'h0000_0000, frac_reg[1]};
            default: rd_word = RESET_WORD;
         endcase
      end
   end

   // ----------------
   // APB answer: data latched in setup, zero wait states
   // ----------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_prdata <= RESET_WORD;
         o_pslverr <= 1'b0;
         o_pready <= 1'b0;
      end else begin
         o_pready <= 1'b1;
         if (setup) begin
            o_prdata <= rd_word;
            o_pslverr <= ~mapped;
         end
      end
   end

   // ----------------
   // Buffer address registers, writable at any time
   // ----------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < 4; i++) begin
            beg_reg[i] <= RESET_WORD;
            end_reg[i] <= RESET_WORD;
         end
      end else if (wr && buf_hit) begin
         if (i_paddr[BUF_END_BIT]) begin
            end_reg[buf_idx] <= i_pwdata; // RULE9
         end else begin
            beg_reg[buf_idx] <= i_pwdata;
         end
      end
   end

   // ----------------
   // Buffer load state and selection
   // ----------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         loaded_reg <= 4'h0;
         rx_sel_reg <= 1'b0;
         tx_sel_reg <= 1'b0;
      end else begin
         loaded_reg <= loaded_next; // RULE6
         rx_sel_reg <= rx_sel_next;
         tx_sel_reg <= tx_sel_next;
      end
   end

   // ----------------
   // Byte counts
   // ----------------
   // One shared transmit count; a fresh load of either buffer restarts it
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tx_cnt_reg <= RESET_WORD;
      end else if (rst_tx || fresh[3:2] != 2'b00) begin
         tx_cnt_reg <= RESET_WORD; // RULE11 RULE12
      end else if (tx_ack) begin
         tx_cnt_reg <= tx_cnt_reg + 32'h0000_0001; // RULE10
      end
   end

   // Separate receive counts; a software write beats a byte finishing
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rx_cnt_reg[0] <= RESET_WORD;
         rx_cnt_reg[1] <= RESET_WORD;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (rst_rx) begin
               rx_cnt_reg[i] <= RESET_WORD; // RULE12
            end else if ((i == 0 && rxcnt_wr_a) || (i == 1 && rxcnt_wr_b)) begin
               rx_cnt_reg[i] <= i_pwdata; // RULE13
            end else if (fresh[i]) begin
               rx_cnt_reg[i] <= RESET_WORD; // RULE11 RULE12
            end else if (rx_ack && xfer_buf_reg == i[0]) begin
               rx_cnt_reg[i] <= rx_cnt_reg[i] + 32'h0000_0001; // RULE10
            end
         end
      end
   end

   // ----------------
   // Transfer engine: one memory access at a time, shared by both channels
   // ----------------
   // A channel reset abandons its access; a late ack is then ignored in idle
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
         o_mem_valid <= 1'b0;
         o_mem_cmd <= '0;
         o_rx_fifo_pop <= 1'b0;
         o_tx_fifo_push <= 1'b0;
         o_tx_fifo_data <= 8'h00;
         xfer_buf_reg <= 1'b0;
         last_tx_reg <= 1'b0;
      end else begin
         o_rx_fifo_pop <= 1'b0;
         o_tx_fifo_push <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (pick_rx) begin
                  state_reg <= ST_RX_WRITE;
                  o_mem_valid <= 1'b1;
                  o_mem_cmd <= '{write: 1'b1, addr: rx_addr, wdata: i_rx_fifo_data}; // RULE4
                  o_rx_fifo_pop <= 1'b1;
                  xfer_buf_reg <= rx_sel_reg;
                  last_tx_reg <= 1'b0;
               end else if (tx_go) begin
                  state_reg <= ST_TX_READ;
                  o_mem_valid <= 1'b1;
                  o_mem_cmd <= '{write: 1'b0, addr: tx_addr, wdata: 8'h00}; // RULE4
                  last_tx_reg <= 1'b1;
               end
            end
            ST_RX_WRITE: begin
               if (rst_rx || i_mem_ack) begin
                  state_reg <= ST_IDLE; // RULE19
                  o_mem_valid <= 1'b0;
               end
            end
            ST_TX_READ: begin
               if (rst_tx) begin
                  state_reg <= ST_IDLE; // RULE19
                  o_mem_valid <= 1'b0;
               end else if (i_mem_ack) begin
                  state_reg <= ST_IDLE;
                  o_mem_valid <= 1'b0;
                  o_tx_fifo_push <= 1'b1;
                  o_tx_fifo_data <= i_mem_rdata;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               o_mem_valid <= 1'b0;
            end
         endcase
      end
   end

   // ----------------
   // Unload flags, mask and interrupt line
   // ----------------
   // Interrupt lags the flag by one cycle, the price of a registered output
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         flag_reg <= 4'h0;
         mask_reg <= 4'h0;
         o_irq <= 1'b0;
      end else begin
         flag_reg <= flag_next; // RULE5
         if (wr && hit_mask) begin
            mask_reg <= i_pwdata[3:0];
         end
         o_irq <= |(flag_reg & mask_reg);
      end
   end

   // ----------------
   // Baud dividers for the two UART controllers
   // ----------------
   // Accumulator restarts on a write to its own period or fraction register so a new rate takes hold cleanly
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < 2; i++) begin
            per_reg[i] <= RESET_BAUD_PER;
            frac_reg[i] <= 1'b0;
            acc_reg[i] <= RESET_WORD;
         end
         o_baud_tick_ch1 <= 1'b0;
         o_baud_tick_ch3 <= 1'b0;
      end else begin
         if (wr && (hit_per1 || hit_per3)) begin
            per_reg[hit_per3] <= i_pwdata[15:0]; // RULE1
         end
         if (wr && (hit_frac1 || hit_frac3)) begin
            frac_reg[hit_frac3] <= i_pwdata[0]; // RULE2
         end
         acc_reg[0] <= (wr && (hit_per1 || hit_frac1)) ? RESET_WORD : step1[31:0];
         acc_reg[1] <= (wr && (hit_per3 || hit_frac3)) ? RESET_WORD : step3[31:0];
         o_baud_tick_ch1 <= step1[32];
         o_baud_tick_ch3 <= step3[32];
      end
   end

endmodule : spdb_dma

// [dv/spdb_checker.sv]
// Port-level assertions for the serial ping-pong DMA
module spdb_checker
   import spdb_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [31:0] i_paddr,
   input wire spdb_mem_s o_mem_cmd,
   input wire logic o_mem_valid,
   input wire logic i_mem_ack,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_rx_fifo_avail,
   input wire logic o_rx_fifo_pop,
   input wire logic o_tx_fifo_push,
   input wire logic [7:0] o_tx_fifo_data,
   input wire logic o_baud_tick_ch1
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // Control writes may reset a channel and drop a request early
   wire logic ctl_wr = i_psel && i_penable && i_paddr == ADDR_CONTROL;
   a_req_held: assert property (o_mem_valid && !i_mem_ack && !ctl_wr |=> o_mem_valid && $stable(o_mem_cmd))
      else $error("memory request changed before ack");
   a_req_drop: assert property (o_mem_valid && i_mem_ack |=> !o_mem_valid)
      else $error("memory request kept after ack");
   a_pop_gap: assert property (o_rx_fifo_pop |=> !o_rx_fifo_pop ##1 !o_rx_fifo_pop)
      else $error("pops too close");
   a_push_gap: assert property (o_tx_fifo_push |=> !o_tx_fifo_push ##1 !o_tx_fifo_push)
      else $error("pushes too close");
   a_pop_with_write: assert property ($rose(o_mem_valid) && o_mem_cmd.write |-> o_rx_fifo_pop)
      else $error("rx write without pop");
   a_push_read_data: assert property (o_mem_valid && i_mem_ack && !o_mem_cmd.write |=>
      o_tx_fifo_push && o_tx_fifo_data == $past(i_mem_rdata))
      else $error("tx byte not pushed");
   a_pop_needs_byte: assert property (o_rx_fifo_pop |-> $past(i_rx_fifo_avail))
      else $error("pop from empty fifo");
   a_tick_single: assert property (o_baud_tick_ch1 |=> !o_baud_tick_ch1)
      else $error("baud tick too long");
   c_rx_write: cover property (o_mem_valid && i_mem_ack && o_mem_cmd.write);
   c_tx_push: cover property (o_tx_fifo_push);
   c_tick: cover property (o_baud_tick_ch1);
endmodule : spdb_checker
bind spdb_dma spdb_checker u_chk (.i_clk, .i_reset, .i_psel, .i_penable, .i_paddr, .o_mem_cmd, .o_mem_valid,
   .i_mem_ack, .i_mem_rdata, .i_rx_fifo_avail, .o_rx_fifo_pop, .o_tx_fifo_push, .o_tx_fifo_data, .o_baud_tick_ch1);

// [dv/spdb_far_model.sv]
// Far-side model: byte RAM with varying latency and the serial FIFO data
module spdb_far_model
   import spdb_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_mem_valid,
   input wire spdb_mem_s i_mem_cmd,
   input wire logic i_rx_avail,
   input wire logic i_rx_pop,
   input wire logic i_tx_push,
   input wire logic [7:0] i_tx_data,
   output logic o_mem_ack,
   output logic [7:0] o_mem_rdata,
   output logic [7:0] o_rx_data,
   output logic [7:0] o_last_w,
   output logic [7:0] o_last_p,
   output int o_writes,
   output int o_pushes
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt = 0;
   int slow = 0;
   logic [7:0] n = 8'h00;
   logic [7:0] junk = 8'h5A;
   initial begin
      o_mem_ack = 1'b0;
      o_mem_rdata = 8'h00;
      o_writes = 0;
      o_pushes = 0;
   end
   // Head byte only while the FIFO holds one; garbage that moves otherwise
   assign o_rx_data = i_rx_avail ? 8'h10 + n : junk;
   // RAM answers after 0, 1 or 2 waits in turn; read data is the address low byte
   always @(posedge i_clk) begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      junk <= ~junk;
      if (i_mem_valid && !o_mem_ack && wait_cnt < slow) wait_cnt <= wait_cnt + 1;
      else if (i_mem_valid && !o_mem_ack) begin
         o_mem_ack <= 1'b1;
         o_mem_rdata <= i_mem_cmd.addr[7:0];
         wait_cnt <= 0;
         slow <= (slow + 1) % 3;
         o_writes <= o_writes + int'(i_mem_cmd.write);
         if (i_mem_cmd.write) o_last_w <= i_mem_cmd.wdata;
      end
      if (i_rx_pop) n <= n + 8'h01;
      if (i_tx_push) o_pushes <= o_pushes + 1;
      if (i_tx_push) o_last_p <= i_tx_data;
   end
endmodule : spdb_far_model

// [dv/tb_top.sv]
// Self-checking bench for the serial ping-pong DMA
module tb_top
   import spdb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
   logic i_tx_fifo_space = 0, i_rx_fifo_avail = 0;
   logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, o_prdata, rd;
   logic o_pready, o_pslverr, o_mem_valid, i_mem_ack, o_tx_fifo_push, o_rx_fifo_pop;
   logic o_baud_tick_ch1, o_baud_tick_ch3, o_irq;
   logic [7:0] i_mem_rdata, o_tx_fifo_data, i_rx_fifo_data, last_w, last_p;
   spdb_mem_s o_mem_cmd;
   int mismatches = 0, cmp_count = 0, writes, pushes, ticks, ticks3;
   localparam logic [31:0] BAUD [4] = '{ADDR_BAUD_PER_CH1, ADDR_BAUD_FRAC_CH1, ADDR_BAUD_PER_CH3, ADDR_BAUD_FRAC_CH3};
   spdb_dma dut (.i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr, .o_mem_cmd, .o_mem_valid, .i_mem_ack, .i_mem_rdata, .i_tx_fifo_space, .o_tx_fifo_push,
      .o_tx_fifo_data, .i_rx_fifo_avail, .i_rx_fifo_data, .o_rx_fifo_pop, .o_baud_tick_ch1, .o_baud_tick_ch3, .o_irq);
   spdb_far_model far (.i_clk, .i_mem_valid(o_mem_valid), .i_mem_cmd(o_mem_cmd), .i_rx_avail(i_rx_fifo_avail),
      .i_rx_pop(o_rx_fifo_pop), .i_tx_push(o_tx_fifo_push), .i_tx_data(o_tx_fifo_data), .o_mem_ack(i_mem_ack),
      .o_mem_rdata(i_mem_rdata), .o_rx_data(i_rx_fifo_data), .o_last_w(last_w), .o_last_p(last_p),
      .o_writes(writes), .o_pushes(pushes));
   // Free-running 100 MHz clock
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // One APB transfer; entered just after a rising edge, leaves one idle cycle
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      k = 0;
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk) i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_pready !== 1'b1 && k < 50);
      if (k >= 50) mismatches++;
      if (k >= 50) test_done();
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clk);
   endtask : apb
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rc(input logic [31:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, rd, e);
   endtask : rc
   // Poll the load bits until the given buffers have unloaded
   task automatic wait_idle(input logic [31:0] m);
      int k;
      for (k = 0; k < 300; k++) begin
         apb(1'b0, ADDR_CONTROL, 32'h0);
         if ((rd & m) === 32'h0) break;
      end
      if (k >= 300) mismatches++;
      if (k >= 300) test_done();
   endtask : wait_idle
   initial begin
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_clk);
      // Baud registers: reset value and field width
      for (int i = 0; i < 4; i++) begin
         rc(BAUD[i], 32'h0, "baud reset");
         wr(BAUD[i], 32'hFFFF_FFFF);
         rc(BAUD[i], i[0] ? 32'h1 : 32'hFFFF, "baud field");
      end
      wr(ADDR_BAUD_PER_CH1, 32'h1);
      wr(ADDR_BAUD_PER_CH3, 32'h1);
      for (int f = 0; f < 2; f++) begin
         wr(ADDR_BAUD_FRAC_CH1, 32'(f));
         wr(ADDR_BAUD_FRAC_CH3, 32'(f));
         ticks = 0;
         ticks3 = 0;
         repeat (2400) begin
            @(posedge i_clk);
            ticks += int'(o_baud_tick_ch1);
            ticks3 += int'(o_baud_tick_ch3);
         end
         chk("baud rate", 32'(ticks >= 2399 * 24 / (100 * (2 + f)) && ticks <= 576 / (2 + f)), 32'h1);
         chk("baud rate ch3", 32'(ticks3 >= 2399 * 24 / (100 * (2 + f)) && ticks3 <= 576 / (2 + f)), 32'h1);
      end
      // Receive ping-pong over A (4 bytes) then B (2 bytes)
      wr(ADDR_CONTROL, 32'h30);
      wr(ADDR_IRQ_MASK, 32'hF);
      wr(ADDR_BUF_BASE, 32'h2000_0000);
      wr(ADDR_BUF_BASE + 4, 32'h2000_0003);
      wr(ADDR_BUF_BASE + 8, 32'h2000_0100);
      wr(ADDR_BUF_BASE + 12, 32'h2000_0101);
      wr(ADDR_CONTROL, 32'h3);
      rc(ADDR_STATUS, 32'h1, "a first");
      rc(ADDR_CONTROL, 32'h3, "loaded");
      i_rx_fifo_avail <= 1'b1;
      wait_idle(32'h3);
      i_rx_fifo_avail <= 1'b0;
      rc(ADDR_RX_COUNT_A, 32'h4, "rx count a");
      rc(ADDR_RX_COUNT_B, 32'h2, "rx count b");
      chk("irq", 32'(o_irq), 32'h1);
      rc(ADDR_IRQ_FLAG, 32'h3, "rx flags");
      rc(ADDR_IRQ_FLAG, 32'h0, "flags cleared");
      chk("irq off", 32'(o_irq), 32'h0);
      chk("rx bytes", 32'(writes), 32'h6);
      chk("rx last", 32'(last_w), 32'h15);
      // Count write loads an idle buffer, a second write unloads it early
      wr(ADDR_RX_COUNT_B, 32'h1);
      rc(ADDR_CONTROL, 32'h2, "load by count");
      rc(ADDR_RX_COUNT_B, 32'h1, "count kept");
      wr(ADDR_RX_COUNT_B, 32'h2);
      rc(ADDR_CONTROL, 32'h0, "count unload");
      rc(ADDR_IRQ_FLAG, 32'h2, "flag b");
      // Reload clears the count; end write unloads early
      wr(ADDR_CONTROL, 32'h1);
      rc(ADDR_RX_COUNT_A, 32'h0, "count cleared");
      wr(ADDR_BUF_BASE + 4, 32'h1FFF_FFFF);
      rc(ADDR_CONTROL, 32'h0, "end unload");
      // Channel reset drops the load and the count
      wr(ADDR_BUF_BASE + 4, 32'h2000_0003);
      wr(ADDR_RX_COUNT_A, 32'h2);
      wr(ADDR_CONTROL, 32'h10);
      rc(ADDR_CONTROL, 32'h0, "after reset");
      rc(ADDR_RX_COUNT_A, 32'h0, "count reset");
      // Transmit: the shared count carries from A into B
      wr(ADDR_BUF_BASE + 16, 32'h2000_0200);
      wr(ADDR_BUF_BASE + 20, 32'h2000_0202);
      wr(ADDR_BUF_BASE + 24, 32'h2000_0300);
      wr(ADDR_BUF_BASE + 28, 32'h2000_0304);
      wr(ADDR_CONTROL, 32'hC);
      i_tx_fifo_space <= 1'b1;
      wait_idle(32'hC);
      i_tx_fifo_space <= 1'b0;
      rc(ADDR_TX_COUNT, 32'h5, "tx count");
      chk("tx bytes", 32'(pushes), 32'h5);
      chk("tx last", 32'(last_p), 32'h04);
      rc(ADDR_IRQ_FLAG, 32'hD, "tx flags");
      // Unmapped word is refused
      apb(1'b0, 32'h4000_C834, 32'h0);
      chk("slverr", 32'(err), 32'h1);
      chk("unmapped", rd, 32'h0);
      test_done();
   end
endmodule : tb_top
